/* hdl/mhr_register_bank.sv */
// Holding register bank served to a serial host: base group plus field unit floats.
// Assumes a front end that parses frames and issues one read word at a time.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Base register 1 returns fixed type code
// - Base status: bit 0 online, rest zero
// - Register 3 returns expected unit count
// - Register 4 returns communicating unit count
// - Registers 5-7 hold online flags, sixteen each; register 8 holds the last two
// - Unit n of group uses bit n-1
// - Registers 9 and 10 read zero
// - Per-unit mode: unit at base ID plus number
// - Unit group: five floats in register pairs
// - Offset mode: unit at 1+10n..10+10n
// - Read holding registers answered at base ID
// - Offline primary/secondary read as NaN
module mhr_register_bank
#(
   parameter logic [15:0] DEVICE_TYPE_CODE = 16'h00A5 // Arbitrary value
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire mhr_pkg::mhr_map_t mapMode,
   input wire logic [7:0] baseId,
   input wire logic baseOnline,
   input wire logic [15:0] expectedUnits,
   input wire logic [mhr_pkg::MAX_UNITS-1:0] unitOnline,
   input wire logic [mhr_pkg::MAX_UNITS-1:0] unitSingleMeas,
   input wire logic unitWrValid,
   input wire mhr_pkg::mhr_unit_wr_t unitWr,
   input wire logic reqValid,
   input wire mhr_pkg::mhr_req_t req,
   output logic reqReady,
   output logic rspValid,
   output mhr_pkg::mhr_rsp_t rsp
);
   import mhr_pkg::*;

   // ==========================================================
   // Storage and state
   typedef enum {ST_IDLE, ST_DECODE, ST_ANSWER} mhr_state_t;
   mhr_state_t state, next_state;
   mhr_req_t reqHold, next_reqHold; // Request under work
   mhr_tgt_t tgtKind, next_tgtKind; // Decoded target
   logic [5:0] tgtUnit, next_tgtUnit; // Unit number, 1-based
   logic [3:0] tgtWord, next_tgtWord; // Word inside group, 0-based
   logic [15:0] commCount, next_commCount; // Units heard now
   logic next_reqReady;
   logic next_rspValid;
   mhr_rsp_t next_rsp;
   // Float store, one row per unit; filled by the radio side
   logic [31:0] unitMem [MAX_UNITS][FLOATS_PER_UNIT];

   // ==========================================================
   // Float store write port
   // Kept apart from control so it needs no reset; reads before a write show junk
   always_ff @(posedge clk)
   begin
      if (unitWrValid && unitWr.radioUnitNumber != 6'h00 &&
          unitWr.radioUnitNumber <= UNIT_ID_MAX[5:0] && unitWr.slot <= SLOT_TERTIARY)
      begin
         unitMem[unitWr.radioUnitNumber - 6'h01][unitWr.slot] <= unitWr.value;
      end
   end

   // ==========================================================
   // Communicating count
   // Counted from the live flags and registered, so it trails a change in them by one clock
   always_comb
   begin
      next_commCount = RST_WORD;
      for (int i = 0; i < MAX_UNITS; i++)
      begin
         next_commCount = next_commCount + {15'h0000, unitOnline[i]};
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         commCount <= RST_WORD;
      else
         commCount <= next_commCount;
   end

   // ==========================================================
   // Request decode and answer
   logic [7:0] idDiff; // Device ID distance from base
   logic [15:0] regIdx; // Address minus one
   logic [15:0] grpQuot; // Group number in offset mode
   logic [15:0] grpRem; // Word in group in offset mode
   logic [FLAG_PAD-1:0] flagsPad; // Flags padded so high group bits read zero
   logic [31:0] unitFloat; // Selected float after NaN override
   logic [2:0] slotSel;
   logic unitUp;

   always_comb
   begin
      next_state = state;
      next_reqHold = reqHold;
      next_tgtKind = tgtKind;
      next_tgtUnit = tgtUnit;
      next_tgtWord = tgtWord;
      next_rspValid = 1'b0;
      next_rsp = rsp;
      idDiff = reqHold.devId - baseId;
      regIdx = reqHold.regAddr - 16'h0001;
      grpQuot = regIdx / UNIT_REGS;
      grpRem = regIdx % UNIT_REGS;
      flagsPad = {{(FLAG_PAD-MAX_UNITS){1'b0}}, unitOnline};
      slotSel = tgtWord[3:1];
      unitUp = unitOnline[tgtUnit - 6'h01];
      unitFloat = unitMem[tgtUnit - 6'h01][slotSel];
      // Offline units lose primary and secondary; single types lose secondary
      if ((slotSel == SLOT_PRIMARY && !unitUp) ||
          (slotSel == SLOT_SECONDARY && (!unitUp || unitSingleMeas[tgtUnit - 6'h01])))
      begin
         unitFloat = FLOAT_NAN;
      end
      case (state)
         ST_IDLE:
         begin
            // Only one read in flight; the front end waits on ready
            if (reqValid)
            begin
               next_reqHold = req;
               next_state = ST_DECODE;
            end
         end
         ST_DECODE:
         begin
            next_tgtKind = TGT_NONE;
            next_tgtUnit = 6'h00;
            next_tgtWord = regIdx[3:0];
            if (reqHold.devId == baseId)
            begin
               // Base group lives at the base ID in both modes
               if (reqHold.regAddr >= REG_BASE_FIRST && reqHold.regAddr <= REG_BASE_LAST)
                  next_tgtKind = TGT_BASE;
               // Address zero must not wrap round into a unit group
               else if (mapMode == offsetGroupMapping && reqHold.regAddr > REG_BASE_LAST &&
                        reqHold.regAddr <= REG_UNIT_LAST)
               begin
                  next_tgtKind = TGT_UNIT;
                  next_tgtUnit = grpQuot[5:0];
                  next_tgtWord = grpRem[3:0];
               end
               else
                  next_tgtKind = TGT_BAD;
            end
            else if (mapMode == perUnitIdMapping && idDiff != 8'h00 && idDiff <= UNIT_ID_MAX)
            begin
               // Wrapped difference is large, so IDs below base fall out here
               if (reqHold.regAddr >= REG_BASE_FIRST && reqHold.regAddr <= REG_BASE_LAST)
               begin
                  next_tgtKind = TGT_UNIT;
                  next_tgtUnit = idDiff[5:0];
               end
               else
                  next_tgtKind = TGT_BAD;
            end
            next_state = ST_ANSWER;
         end
         ST_ANSWER:
         begin
            next_rspValid = 1'b1;
            next_rsp.hit = (tgtKind != TGT_NONE);
            next_rsp.illegalAddr = (tgtKind == TGT_BAD);
            next_rsp.data = RST_WORD;
            if (tgtKind == TGT_BASE)
            begin
               case (tgtWord)
                  WRD_TYPE: next_rsp.data = DEVICE_TYPE_CODE;
                  WRD_STATUS: next_rsp.data[STATUS_ONLINE_BIT] = baseOnline;
                  WRD_EXPECTED: next_rsp.data = expectedUnits;
                  WRD_COMM: next_rsp.data = commCount;
                  WRD_RSVD_A, WRD_RSVD_B: next_rsp.data = RST_WORD;
                  default:
                  begin
                     // Bit n-1 of a group word is unit n of that group
                     if (tgtWord >= WRD_FLAGS_FIRST && tgtWord <= WRD_FLAGS_LAST)
                        next_rsp.data = flagsPad[(32'(tgtWord - WRD_FLAGS_FIRST))*FLAG_GROUP +: FLAG_GROUP];
                  end
               endcase
            end
            else if (tgtKind == TGT_UNIT)
            begin
               // Even word carries the high half
               if (tgtWord[0] == 1'b0)
                  next_rsp.data = unitFloat[31:16];
               else
                  next_rsp.data = unitFloat[15:0];
            end
            next_state = ST_IDLE;
         end
         default:
            next_state = ST_IDLE;
      endcase
      next_reqReady = (next_state == ST_IDLE);
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state <= ST_IDLE;
         reqHold <= '0;
         tgtKind <= TGT_NONE;
         tgtUnit <= 6'h00;
         tgtWord <= 4'h0;
         reqReady <= 1'b1;
         rspValid <= 1'b0;
         rsp <= '0;
      end
      else
      begin
         state <= next_state;
         reqHold <= next_reqHold;
         tgtKind <= next_tgtKind;
         tgtUnit <= next_tgtUnit;
         tgtWord <= next_tgtWord;
         reqReady <= next_reqReady;
         rspValid <= next_rspValid;
         rsp <= next_rsp;
      end
   end

   // ==========================================================
   // Checks
   logic baseHit;
   assign baseHit = rspValid && tgtKind == TGT_BASE;

   sequence reqTaken_s;
      reqValid && reqReady;
   endsequence

   sequence answerOut_s;
      !rspValid ##1 rspValid && reqReady;
   endsequence

   answer_timing_a: assert property (@(posedge clk) disable iff (!resetn)
      reqTaken_s |-> ##2 answerOut_s)
      else $error("Answer not two cycles after request");

   type_code_a: assert property (@(posedge clk) disable iff (!resetn)
      baseHit && tgtWord == WRD_TYPE |-> rsp.data == DEVICE_TYPE_CODE)
      else $error("Base type code wrong");

   status_bits_a: assert property (@(posedge clk) disable iff (!resetn)
      baseHit && tgtWord == WRD_STATUS |-> rsp.data == {15'h0000, $past(baseOnline)})
      else $error("Base status word wrong");

   expected_count_a: assert property (@(posedge clk) disable iff (!resetn)
      baseHit && tgtWord == WRD_EXPECTED |-> rsp.data == $past(expectedUnits))
      else $error("Expected count wrong");

   comm_count_a: assert property (@(posedge clk) disable iff (!resetn)
      baseHit && tgtWord == WRD_COMM |-> rsp.data == $past(commCount))
      else $error("Communicating count wrong");

   flag_bits_a: assert property (@(posedge clk) disable iff (!resetn)
      baseHit && tgtWord == WRD_FLAGS_LAST |-> rsp.data == {14'h0000, $past(unitOnline[49:48])})
      else $error("Last flag group wrong");

   reserved_zero_a: assert property (@(posedge clk) disable iff (!resetn)
      baseHit && (tgtWord == WRD_RSVD_A || tgtWord == WRD_RSVD_B) |-> rsp.data == RST_WORD)
      else $error("Reserved word not zero");

   unit_id_map_a: assert property (@(posedge clk) disable iff (!resetn)
      state == ST_DECODE && mapMode == perUnitIdMapping && reqHold.regAddr == 16'h0005 &&
      reqHold.devId == baseId + 8'h03 |=> tgtKind == TGT_UNIT && tgtUnit == 6'h03 &&
      tgtWord == 4'h4)
      else $error("Per-unit ID decode wrong");

   offset_map_a: assert property (@(posedge clk) disable iff (!resetn)
      state == ST_DECODE && mapMode == offsetGroupMapping && reqHold.devId == baseId &&
      reqHold.regAddr == 16'h0014 |=> tgtKind == TGT_UNIT && tgtUnit == 6'h01 &&
      tgtWord == 4'h9)
      else $error("Offset group decode wrong");

   offline_nan_a: assert property (@(posedge clk) disable iff (!resetn)
      rspValid && tgtKind == TGT_UNIT && tgtWord == 4'h4 &&
      !$past(unitOnline[tgtUnit - 6'h01]) |-> rsp.data == FLOAT_NAN[31:16])
      else $error("Offline primary not NaN");

   // Bad addresses still answer as ours, with a zero word
   illegal_zero_a: assert property (@(posedge clk) disable iff (!resetn)
      rspValid && tgtKind == TGT_BAD |-> rsp.hit && rsp.illegalAddr && rsp.data == RST_WORD)
      else $error("Illegal address answer wrong");

   address_zero_a: assert property (@(posedge clk) disable iff (!resetn)
      state == ST_DECODE && reqHold.devId == baseId && reqHold.regAddr == 16'h0000 |=>
      tgtKind == TGT_BAD)
      else $error("Address zero not refused");

   miss_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
      rspValid && tgtKind == TGT_NONE |-> !rsp.hit && rsp.data == RST_WORD)
      else $error("Foreign device ID answered as ours");

   answer_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
      rspValid |=> !rspValid)
      else $error("Answer strobe longer than one cycle");
endmodule

`default_nettype wire

/* hdl/mhr_pkg.sv */
// Shared constants and carriers for the holding register bank.
// Assumes one 100 MHz clock and a synchronous active-low reset in all users.
package mhr_pkg;
   // ==========================================================
   // Base group register addresses (1-based, as the host sees them)
   localparam logic [15:0] REG_BASE_FIRST = 16'h0001;
   localparam logic [15:0] REG_BASE_LAST = 16'h000A;
   // Word positions inside the base group (address minus one)
   localparam logic [3:0] WRD_TYPE = 4'h0;
   localparam logic [3:0] WRD_STATUS = 4'h1;
   localparam logic [3:0] WRD_EXPECTED = 4'h2;
   localparam logic [3:0] WRD_COMM = 4'h3;
   localparam logic [3:0] WRD_FLAGS_FIRST = 4'h4;
   localparam logic [3:0] WRD_FLAGS_LAST = 4'h7;
   localparam logic [3:0] WRD_RSVD_A = 4'h8;
   localparam logic [3:0] WRD_RSVD_B = 4'h9;
   // Status field position: only the online bit is defined
   localparam int STATUS_ONLINE_BIT = 0;
   // ==========================================================
   // Field unit geometry
   localparam int MAX_UNITS = 50;
   localparam int FLAG_GROUP = 16;
   localparam int FLAG_PAD = 64;
   localparam int FLOATS_PER_UNIT = 5;
   localparam logic [15:0] UNIT_REGS = 16'h000A;
   localparam logic [15:0] REG_UNIT_LAST = 16'h01FE;
   localparam logic [7:0] UNIT_ID_MAX = 8'h32;
   // Float slots inside a unit group
   localparam logic [2:0] SLOT_TYPE = 3'h0;
   localparam logic [2:0] SLOT_STATUS = 3'h1;
   localparam logic [2:0] SLOT_PRIMARY = 3'h2;
   localparam logic [2:0] SLOT_SECONDARY = 3'h3;
   localparam logic [2:0] SLOT_TERTIARY = 3'h4;
   // Quiet not-a-number in single precision
   localparam logic [31:0] FLOAT_NAN = 32'h7FC0_0000;
   // Reset values
   localparam logic [15:0] RST_WORD = 16'h0000;
   // ==========================================================
   // Mapping modes
   typedef enum logic {perUnitIdMapping, offsetGroupMapping} mhr_map_t;
   // What a decoded request points at
   typedef enum logic [1:0] {TGT_NONE, TGT_BASE, TGT_UNIT, TGT_BAD} mhr_tgt_t;
   // Read request from the serial front end
   typedef struct packed {
      logic [7:0] devId;
      logic [15:0] regAddr;
   } mhr_req_t;
   // Answer: hit means the device ID is ours
   typedef struct packed {
      logic hit;
      logic illegalAddr;
      logic [15:0] data;
   } mhr_rsp_t;
   // Float update from the radio side
   typedef struct packed {
      logic [5:0] radioUnitNumber;
      logic [2:0] slot;
      logic [31:0] value;
   } mhr_unit_wr_t;
endpackage

/* tb/mhr_host_model.sv */
// Serial host stand-in: issues holding register reads one word at a time.
// Assumes the bank's read handshake and the carriers of mhr_pkg.
`timescale 1ns/1ps
`default_nettype none
module mhr_host_model
(
   input wire logic clk,
   input wire logic reqReady,
   input wire logic rspValid,
   input wire mhr_pkg::mhr_rsp_t rsp,
   output logic reqValid,
   output mhr_pkg::mhr_req_t req
);
   import mhr_pkg::*;
   // Handshake limits that ran out; the bench counts them as mismatches
   int timeouts = 0;
   // ==========================================================
   // Request side
   // Idle at time zero
   initial
   begin
      reqValid = 1'b0;
      req = '0;
   end
   // One holding register read; request held until the edge that takes it
   task automatic readReg(input logic [7:0] dev, input logic [15:0] addr, output mhr_rsp_t r);
      int n;
      n = 0;
      @(posedge clk);
      reqValid <= 1'b1;
      req <= '{devId: dev, regAddr: addr};
      do @(posedge clk); while (reqReady !== 1'b1 && ++n < 20);
      if (reqReady !== 1'b1)
         timeouts++;
      reqValid <= 1'b0;
      // Released lines show the inverse, so a stale request cannot pass
      req <= ~req;
      n = 0;
      do @(posedge clk); while (rspValid !== 1'b1 && ++n < 20);
      if (rspValid !== 1'b1)
         timeouts++;
      r = rsp;
   endtask
   // ==========================================================
   // Host-side decode of an online flag word
   // Largest weight first, the way a host program walks it
   function automatic logic [15:0] decodeFlags(input logic [15:0] v);
      logic [15:0] seen;
      seen = '0;
      for (int k = 15; k >= 0; k--)
      begin
         if (v >= (16'h0001 << k))
         begin
            v = v - (16'h0001 << k);
            seen[k] = 1'b1;
         end
      end
      return seen;
   endfunction
endmodule
`default_nettype wire

/* tb/tb_mhr_register_bank.sv */
// Self-checking bench for the holding register bank, reads go through the host model.
// Assumes one clock, synchronous active-low reset, answers two edges after a take.
`timescale 1ns/1ps
`default_nettype none
module tb_mhr_register_bank;
   import mhr_pkg::*;
   // ==========================================================
   // Table of reads: mode, device ID, address, then the expected answer
   typedef struct packed {
      logic map;
      logic [7:0] dev;
      logic [15:0] addr;
      logic hit;
      logic ill;
      logic [15:0] data;
   } mhr_row_t;
   localparam logic [15:0] TYPE_CODE = 16'h00A5; // Arbitrary value
   localparam logic [7:0] BASE = 8'h10; // Base device ID
   // Floats are 41uu_00ss so each half names unit and slot
   mhr_row_t rows [28] = '{
      '{1'b1, BASE, 16'h0001, 1'b1, 1'b0, TYPE_CODE},
      '{1'b1, BASE, 16'h0002, 1'b1, 1'b0, 16'h0001},
      '{1'b1, BASE, 16'h0003, 1'b1, 1'b0, 16'h0007},
      '{1'b1, BASE, 16'h0004, 1'b1, 1'b0, 16'h0006},
      '{1'b1, BASE, 16'h0005, 1'b1, 1'b0, 16'h8081},
      '{1'b1, BASE, 16'h0006, 1'b1, 1'b0, 16'h0001},
      '{1'b1, BASE, 16'h0007, 1'b1, 1'b0, 16'h0000},
      '{1'b1, BASE, 16'h0008, 1'b1, 1'b0, 16'h0003},
      '{1'b1, BASE, 16'h0009, 1'b1, 1'b0, 16'h0000},
      '{1'b1, BASE, 16'h000A, 1'b1, 1'b0, 16'h0000},
      '{1'b1, BASE, 16'h000B, 1'b1, 1'b0, 16'h4101},
      '{1'b1, BASE, 16'h000C, 1'b1, 1'b0, 16'h0000},
      '{1'b1, BASE, 16'h0010, 1'b1, 1'b0, 16'h0002},
      '{1'b1, BASE, 16'h01FD, 1'b1, 1'b0, 16'h4132},
      '{1'b1, BASE, 16'h01FE, 1'b1, 1'b0, 16'h0004},
      '{1'b1, BASE, 16'h01FF, 1'b1, 1'b1, 16'h0000},
      '{1'b0, 8'h11, 16'h0005, 1'b1, 1'b0, 16'h4101},
      '{1'b0, 8'h11, 16'h0006, 1'b1, 1'b0, 16'h0002},
      '{1'b0, 8'h42, 16'h000A, 1'b1, 1'b0, 16'h0004},
      '{1'b0, BASE, 16'h0001, 1'b1, 1'b0, TYPE_CODE},
      '{1'b0, 8'h11, 16'h000B, 1'b1, 1'b1, 16'h0000},
      '{1'b0, 8'h05, 16'h0001, 1'b0, 1'b0, 16'h0000},
      '{1'b0, 8'h12, 16'h0005, 1'b1, 1'b0, 16'h7FC0},
      '{1'b0, 8'h12, 16'h0006, 1'b1, 1'b0, 16'h0000},
      '{1'b0, 8'h21, 16'h0007, 1'b1, 1'b0, 16'h7FC0},
      '{1'b0, 8'h13, 16'h0005, 1'b1, 1'b0, 16'h7FC0},
      '{1'b1, BASE, 16'h0014, 1'b1, 1'b0, 16'h0004},
      '{1'b1, BASE, 16'h0000, 1'b1, 1'b1, 16'h0000}
   };
   // ==========================================================
   // Signals
   logic clk, resetn, baseOnline, unitWrValid, reqValid, reqReady, rspValid;
   mhr_map_t mapMode;
   logic [7:0] baseId;
   logic [15:0] expectedUnits;
   logic [MAX_UNITS-1:0] unitOnline, unitSingleMeas;
   mhr_unit_wr_t unitWr;
   mhr_req_t req;
   mhr_rsp_t rsp, r;
   int fails = 0;
   int comparisons = 0;
   // ==========================================================
   // Instances
   mhr_register_bank #(.DEVICE_TYPE_CODE(TYPE_CODE)) mhr_register_bank_i (.clk(clk),
      .resetn(resetn), .mapMode(mapMode), .baseId(baseId), .baseOnline(baseOnline),
      .expectedUnits(expectedUnits), .unitOnline(unitOnline), .unitSingleMeas(unitSingleMeas),
      .unitWrValid(unitWrValid), .unitWr(unitWr), .reqValid(reqValid), .req(req),
      .reqReady(reqReady), .rspValid(rspValid), .rsp(rsp));
   mhr_host_model mhr_host_model_i (.clk(clk), .reqReady(reqReady), .rspValid(rspValid),
      .rsp(rsp), .reqValid(reqValid), .req(req));
   // ==========================================================
   // Helpers
   // Word compare; one-bit results are widened by the caller
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Single exit point for both normal end and watchdog
   task automatic print_verdict();
      if (fails == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // One float into the store; valid stays up across back-to-back writes
   task automatic wrFloat(input logic [5:0] u, input logic [2:0] s);
      @(posedge clk);
      unitWrValid <= 1'b1;
      unitWr <= '{u, s, {8'h41, 2'h0, u, 8'h00, 5'h00, s}};
   endtask
   // 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Watchdog: the whole run needs well under 1000 cycles
   initial
   begin
      #50000;
      fails++;
      print_verdict();
   end
   // ==========================================================
   // Main sequence
   initial
   begin
      mapMode = offsetGroupMapping;
      baseId = BASE;
      baseOnline = 1'b1;
      expectedUnits = 16'h0007;
      // Units 1, 8, 16, 17, 49, 50 online; unit 2 offline
      unitOnline = 50'h3_0000_0001_8081;
      unitSingleMeas = 50'h0_0000_0001_0000;
      unitWrValid = 1'b0;
      unitWr = '0;
      resetn = 1'b0;
      repeat (3) @(posedge clk);
      chk({15'h0000, rspValid}, 16'h0000);
      chk({15'h0000, reqReady}, 16'h0001);
      resetn <= 1'b1;
      for (int s = 0; s < FLOATS_PER_UNIT; s++)
         wrFloat(6'h01, 3'(s));
      wrFloat(6'h02, SLOT_PRIMARY);
      wrFloat(6'h02, SLOT_SECONDARY);
      wrFloat(6'h11, SLOT_SECONDARY);
      wrFloat(6'h32, SLOT_TERTIARY);
      @(posedge clk);
      unitWrValid <= 1'b0;
      foreach (rows[i])
      begin
         @(posedge clk);
         mapMode <= mhr_map_t'(rows[i].map);
         mhr_host_model_i.readReg(rows[i].dev, rows[i].addr, r);
         chk({15'h0000, r.hit}, {15'h0000, rows[i].hit});
         if (rows[i].hit)
         begin
            chk({15'h0000, r.illegalAddr}, {15'h0000, rows[i].ill});
            chk(r.data, rows[i].data);
         end
      end
      // Status and count follow the live inputs
      @(posedge clk);
      baseOnline <= 1'b0;
      unitOnline <= 50'h0_0000_0000_000F;
      mapMode <= offsetGroupMapping;
      mhr_host_model_i.readReg(BASE, 16'h0002, r);
      chk(r.data, 16'h0000);
      mhr_host_model_i.readReg(BASE, 16'h0004, r);
      chk(r.data, 16'h0004);
      mhr_host_model_i.readReg(BASE, 16'h0005, r);
      chk(mhr_host_model_i.decodeFlags(r.data), 16'h000F);
      // Reset in mid-run clears the answer, then reads resume
      @(posedge clk);
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      chk({15'h0000, rspValid}, 16'h0000);
      chk(rsp.data, 16'h0000);
      resetn <= 1'b1;
      mhr_host_model_i.readReg(BASE, 16'h0001, r);
      chk(r.data, TYPE_CODE);
      chk(16'(mhr_host_model_i.timeouts), 16'h0000);
      print_verdict();
   end
endmodule
`default_nettype wire
